// ===== quad_conv_defines.vh
// Constants shared by the quad converter readout logic.
// Functional notes
// - Sampling starts on a rising edge of the convert strobe and conversion plus readout start on its next falling edge.
// - The conversion sequence advances only on serial clock edges supplied by the host.
// - In single-edge mode each falling serial clock edge presents the next result bit, most significant first.
// - In dual-edge mode both serial clock edges advance each lane by one bit, most significant first.
// - An echo clock follows the serial clock with the same delay as the data lanes.
// - When the echo disable input is high the echo clock is not driven.
// - The block resets on power-up or low supply and reinitialises once the supply is back.
// - Each channel result is 13 bits: the MSB is loaded at the strobe fall and the other bits take 12 shift edges in either mode.
// - Results are two's complement words.
`ifndef QUAD_CONV_DEFINES_VH
`define QUAD_CONV_DEFINES_VH
`define RES_BITS 13
`define RES_MSB 12
`define CNT_W 4
`define CNT_ZERO 4'h0
`define LAST_SHIFT 4'hB
`define LANES 4
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define SETTLE_MS 10
`define CLK_KHZ 25000
`endif

// ===== quad_conv.v
// Quad converter readout logic with sample FIFO.
`timescale 1ns/1ps
`include "quad_conv_defines.vh"

module sample_fifo #(
  parameter WIDTH = 52,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
  assign out_data_o = mem_reg[rd_reg];
  assign push = ce_i & in_valid_i & in_ready_o;
  assign pop = ce_i & out_valid_o & out_ready_i;
  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ***************************************************
// One data lane: parallel load, then MSB-first shift.
// ***************************************************
module lane_shifter #(
  parameter WIDTH = 13
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire load_i,
  input wire [WIDTH-1:0] load_data_i,
  input wire shift_i,
  output reg lane_o
);
  reg [WIDTH-1:0] sh_reg;
  // The lane pin is registered so that it moves on the same edge as the echo clock.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_reg <= {WIDTH{1'b0}};
      lane_o <= 1'b0;
    end else if (ce_i) begin
      if (load_i) begin
        sh_reg <= load_data_i;
        lane_o <= load_data_i[WIDTH-1];
      end else if (shift_i) begin
        sh_reg <= {sh_reg[WIDTH-2:0], 1'b0};
        lane_o <= sh_reg[WIDTH-2];
      end
    end
  end
endmodule

module quad_conv #(
  parameter SETTLE_CYCLES = `SETTLE_MS * `CLK_KHZ
) (
  input wire mclk_i,
  input wire arst_n_i,
  input wire ce_i,
  input wire convert_strobe_n_i,
  input wire serial_clock_i,
  input wire edge_rate_select_i,
  input wire echo_disable_i,
  input wire sample_valid_i,
  output wire sample_ready_o,
  input wire [`RES_MSB:0] ch1_code_i,
  input wire [`RES_MSB:0] ch2_code_i,
  input wire [`RES_MSB:0] ch3_code_i,
  input wire [`RES_MSB:0] ch4_code_i,
  output wire lane_one_out_o,
  output wire lane_two_out_o,
  output wire lane_three_out_o,
  output wire lane_four_out_o,
  output reg echo_clock_out_o,
  output reg echo_clock_oe_o,
  output reg busy_o,
  output reg settled_o
);
  // ***************************************************
  // Reset release and input synchronisers.
  // ***************************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_SAMPLE = 2'b01;
  localparam ST_SHIFT = 2'b10;
  reg rst_s1_reg;
  reg rst_n_reg;
  reg [1:0] cnv_sync_reg;
  reg [1:0] sck_sync_reg;
  reg [1:0] mode_sync_reg;
  reg [1:0] dis_sync_reg;
  reg cnv_d_reg;
  reg sck_d_reg;
  reg [1:0] state_reg;
  reg [`CNT_W-1:0] bits_reg;
  reg [31:0] settle_reg;
  wire [`LANES*`RES_BITS-1:0] load_word;
  wire lane_load;
  wire lane_shift;
  wire [`LANES*`RES_BITS-1:0] fifo_out;
  wire fifo_valid;
  wire cnv_rise;
  wire cnv_fall;
  wire sck_rise;
  wire sck_fall;
  wire shift_edge;
  wire load;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end
  always @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      // The strobe idles low, so the detector starts low to avoid a false edge after reset.
      cnv_sync_reg <= 2'b00;
      sck_sync_reg <= 2'b00;
      mode_sync_reg <= 2'b00;
      dis_sync_reg <= 2'b00;
      cnv_d_reg <= 1'b0;
      sck_d_reg <= 1'b0;
    end else if (ce_i) begin
      cnv_sync_reg <= {cnv_sync_reg[0], convert_strobe_n_i};
      sck_sync_reg <= {sck_sync_reg[0], serial_clock_i};
      mode_sync_reg <= {mode_sync_reg[0], edge_rate_select_i};
      dis_sync_reg <= {dis_sync_reg[0], echo_disable_i};
      cnv_d_reg <= cnv_sync_reg[1];
      sck_d_reg <= sck_sync_reg[1];
    end
  end
  assign cnv_rise = cnv_sync_reg[1] & ~cnv_d_reg;
  assign cnv_fall = ~cnv_sync_reg[1] & cnv_d_reg;
  assign sck_rise = sck_sync_reg[1] & ~sck_d_reg;
  assign sck_fall = ~sck_sync_reg[1] & sck_d_reg;
  assign shift_edge = sck_fall | (mode_sync_reg[1] & sck_rise);
  // ***************************************************
  // Sample buffer: one word holds all four channels.
  // ***************************************************
  assign load = ce_i & (state_reg == ST_SAMPLE) & cnv_fall & fifo_valid;
  sample_fifo #(
    .WIDTH(`LANES*`RES_BITS),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_reg),
    .ce_i(ce_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .in_data_i({ch1_code_i, ch2_code_i, ch3_code_i, ch4_code_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(load),
    .out_data_o(fifo_out)
  );
  // ***************************************************
  // Conversion sequence and lane shifters.
  // ***************************************************
  // An empty buffer loads zeros so that a strobe without data still reads out cleanly.
  assign load_word = fifo_valid ? fifo_out : {(`LANES*`RES_BITS){1'b0}};
  assign lane_load = (state_reg == ST_SAMPLE) & cnv_fall;
  // A strobe rise during readout aborts the frame, so it takes priority over a shift.
  assign lane_shift = (state_reg == ST_SHIFT) & ~cnv_rise & shift_edge;
  lane_shifter #(
    .WIDTH(`RES_BITS)
  ) u_lane1 (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_reg),
    .ce_i(ce_i),
    .load_i(lane_load),
    .load_data_i(load_word[4*`RES_BITS-1:3*`RES_BITS]),
    .shift_i(lane_shift),
    .lane_o(lane_one_out_o)
  );
  lane_shifter #(
    .WIDTH(`RES_BITS)
  ) u_lane2 (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_reg),
    .ce_i(ce_i),
    .load_i(lane_load),
    .load_data_i(load_word[3*`RES_BITS-1:2*`RES_BITS]),
    .shift_i(lane_shift),
    .lane_o(lane_two_out_o)
  );
  lane_shifter #(
    .WIDTH(`RES_BITS)
  ) u_lane3 (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_reg),
    .ce_i(ce_i),
    .load_i(lane_load),
    .load_data_i(load_word[2*`RES_BITS-1:`RES_BITS]),
    .shift_i(lane_shift),
    .lane_o(lane_three_out_o)
  );
  lane_shifter #(
    .WIDTH(`RES_BITS)
  ) u_lane4 (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_reg),
    .ce_i(ce_i),
    .load_i(lane_load),
    .load_data_i(load_word[`RES_BITS-1:0]),
    .shift_i(lane_shift),
    .lane_o(lane_four_out_o)
  );
  // The load presents the MSB, so the frame ends after twelve further shift edges.
  // Serial clock edges outside a frame are ignored.
  always @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_IDLE;
      bits_reg <= `CNT_ZERO;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      case (state_reg)
        ST_IDLE: begin
          if (cnv_rise) begin
            state_reg <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (cnv_fall) begin
            bits_reg <= `CNT_ZERO;
            busy_o <= 1'b1;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cnv_rise) begin
            busy_o <= 1'b0;
            state_reg <= ST_SAMPLE;
          end else if (shift_edge) begin
            bits_reg <= bits_reg + 1'b1;
            if (bits_reg == `LAST_SHIFT) begin
              busy_o <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // ***************************************************
  // Echo clock and settling flag.
  // ***************************************************
  always @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      echo_clock_out_o <= 1'b0;
      echo_clock_oe_o <= 1'b0;
      settle_reg <= 32'h0000_0000;
      settled_o <= 1'b0;
    end else if (ce_i) begin
      // Taken from the same stage that times the lane shifts, so echo and data move together.
      echo_clock_out_o <= sck_sync_reg[1];
      echo_clock_oe_o <= ~dis_sync_reg[1];
      if (settle_reg == SETTLE_CYCLES - 1) begin
        settled_o <= 1'b1;
      end else begin
        settle_reg <= settle_reg + 32'h0000_0001;
      end
    end
  end
endmodule

// ===== quad_conv_asserts.sv
// Concurrent checks on the quad converter readout ports.
`timescale 1ns/1ps
module quad_conv_asserts #(
  parameter SETTLE_CYCLES = 20
) (
  input wire mclk_i,
  input wire arst_n_i,
  input wire convert_strobe_n_i,
  input wire serial_clock_i,
  input wire edge_rate_select_i,
  input wire echo_disable_i,
  input wire lane_one_out_o,
  input wire echo_clock_out_o,
  input wire echo_clock_oe_o,
  input wire busy_o,
  input wire settled_o
);
  integer up_cnt;
  // ****
  // Cycles since reset release, saturating past the settle time.
  // ****
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_cnt <= 0;
    end else if (up_cnt < SETTLE_CYCLES + 20) begin
      up_cnt <= up_cnt + 1;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  a_echo_follow: assert property (echo_clock_oe_o && $rose(serial_clock_i) |-> ##[2:5] $rose(echo_clock_out_o))
    else $error("echo clock missed a serial clock rise");
  a_busy_start: assert property ($fell(convert_strobe_n_i) |-> ##[2:6] busy_o)
    else $error("strobe fall did not start readout");
  a_busy_hold: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("readout ended too early");
  a_lane_quiet: assert property ($changed(lane_one_out_o) |-> busy_o || $past(busy_o))
    else $error("lane changed outside readout");
  a_sdr_quiet: assert property (!edge_rate_select_i && busy_o && $rose(serial_clock_i)
    |-> ##1 $stable(lane_one_out_o) [*5])
    else $error("lane shifted on a rising edge in single-edge mode");
  a_settle_early: assert property (settled_o |-> up_cnt >= SETTLE_CYCLES)
    else $error("settled raised too early");
  a_settle_late: assert property (up_cnt == SETTLE_CYCLES + 8 |-> settled_o)
    else $error("settled not raised in time");
  a_echo_off: assert property (echo_disable_i [*6] |-> !echo_clock_oe_o)
    else $error("echo clock driven while disabled");
  cover property (busy_o && edge_rate_select_i);
  cover property ($rose(settled_o));
  cover property (settled_o && !echo_clock_oe_o);
endmodule

// ===== conv_host.sv
// Sample host model that strobes conversions and reads the four lanes.
`timescale 1ns/1ps
module conv_host (
  output reg convert_strobe_n_o,
  output reg serial_clock_o,
  input wire echo_clock_i,
  input wire [3:0] lanes_i
);
  reg [51:0] cap;
  initial begin
    convert_strobe_n_o = 1'b0;
    serial_clock_o = 1'b0;
    cap = 52'h0;
  end
  task grab(input integer b);
    begin
      cap[39 + b] = lanes_i[3];
      cap[26 + b] = lanes_i[2];
      cap[13 + b] = lanes_i[1];
      cap[b] = lanes_i[0];
    end
  endtask
  // ****
  // One frame; the MSB is taken after a fixed delay, later bits just after each echo edge (falling only in single-edge mode), the clock stands low between frames.
  // ****
  task read_frame(input dual, output [51:0] word);
    integer n;
    integer b;
    begin
      #13 convert_strobe_n_o = 1'b1;
      #120 convert_strobe_n_o = 1'b0;
      #240 grab(12);
      fork
        for (n = 0; n < (dual ? 12 : 24); n = n + 1) begin
          serial_clock_o = ~serial_clock_o;
          #160;
        end
        for (b = 11; b >= 0; b = b - 1) begin
          if (dual) begin
            @(echo_clock_i);
          end else begin
            @(negedge echo_clock_i);
          end
          #1 grab(b);
        end
      join
      word = cap;
    end
  endtask
endmodule

// ===== quad_conv_bench.sv
// Self-checking bench for the quad converter readout block.
`timescale 1ns/1ps
module quad_conv_bench;
  localparam SETTLE = 20;
  reg mclk = 1'b0;
  reg arst_n = 1'b0;
  reg mode = 1'b0;
  reg echo_off = 1'b0;
  reg push = 1'b0;
  reg [51:0] code = 52'h0;
  reg [51:0] got;
  wire strobe_n, sck, ready, echo, echo_oe, busy, settled;
  wire [3:0] lanes;
  integer err_total = 0;
  integer cmp_count = 0;
  integer cycles = 0;
  integer k;
  always #20 mclk = ~mclk;
  quad_conv #(.SETTLE_CYCLES(SETTLE)) quad_conv_i (.mclk_i(mclk), .arst_n_i(arst_n), .ce_i(1'b1),
    .convert_strobe_n_i(strobe_n), .serial_clock_i(sck), .edge_rate_select_i(mode), .echo_disable_i(echo_off),
    .sample_valid_i(push), .sample_ready_o(ready), .ch1_code_i(code[51:39]), .ch2_code_i(code[38:26]),
    .ch3_code_i(code[25:13]), .ch4_code_i(code[12:0]), .lane_one_out_o(lanes[3]), .lane_two_out_o(lanes[2]),
    .lane_three_out_o(lanes[1]), .lane_four_out_o(lanes[0]), .echo_clock_out_o(echo),
    .echo_clock_oe_o(echo_oe), .busy_o(busy), .settled_o(settled));
  conv_host conv_host_i (.convert_strobe_n_o(strobe_n), .serial_clock_o(sck), .echo_clock_i(echo), .lanes_i(lanes));
  // ****
  // Shared checking and stimulus tasks.
  // ****
  task summarize;
    begin
      $display("checks %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      summarize;
    end
  end
  task check(input [51:0] seen, input [51:0] exp, input string what);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  function [51:0] pattern(input [12:0] n);
    pattern = {13'h1000 ^ n, 13'h0fff - n, 13'h0123 * n, 13'h1555 ^ n};
  endfunction
  task test_settle;
    begin
      check({51'h0, settled}, 52'h0, "settled early");
      repeat (SETTLE + 8) @(posedge mclk);
      check({51'h0, settled}, 52'h1, "settled late");
      $display("settle test done");
    end
  endtask
  task test_echo;
    begin
      echo_off <= 1'b1;
      repeat (8) @(posedge mclk);
      check({51'h0, echo_oe}, 52'h0, "echo enable off");
      echo_off <= 1'b0;
      repeat (8) @(posedge mclk);
      check({51'h0, echo_oe}, 52'h1, "echo enable on");
      $display("echo test done");
    end
  endtask
  task test_fifo;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        @(posedge mclk);
        code <= pattern(k[12:0]);
        push <= 1'b1;
        @(posedge mclk);
        push <= 1'b0;
      end
      #1 check({51'h0, ready}, 52'h0, "fifo full");
      for (k = 0; k < 9; k = k + 1) begin
        @(posedge mclk);
        mode <= k[0];
        repeat (4) @(posedge mclk);
        conv_host_i.read_frame(k[0], got);
        check(got, (k < 8) ? pattern(k[12:0]) : 52'h0, "lane word");
        check({51'h0, busy}, 52'h0, "busy after frame");
      end
      $display("fifo test done");
    end
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    test_settle;
    test_echo;
    test_fifo;
    summarize;
  end
endmodule
bind quad_conv quad_conv_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) quad_conv_asserts_i (.mclk_i(mclk_i),
  .arst_n_i(arst_n_i), .convert_strobe_n_i(convert_strobe_n_i), .serial_clock_i(serial_clock_i),
  .edge_rate_select_i(edge_rate_select_i), .echo_disable_i(echo_disable_i), .lane_one_out_o(lane_one_out_o),
  .echo_clock_out_o(echo_clock_out_o), .echo_clock_oe_o(echo_clock_oe_o), .busy_o(busy_o), .settled_o(settled_o));
